// ---- logic/udrt_pin_sample.sv ----
// Samples one pin on clk and flags its falling edge
`timescale 1ns/1ns
module udrt_pin_sample
    import udrt_pkg::*;
(
    // Clock and reset
    input  wire logic clk,
    input  wire logic nrst,
    // Pin and results
    input  wire logic pin,
    output logic      level,
    output logic      fall
);

    udrt_pin_s s_r;
    udrt_pin_s s_nxt;

    always_comb begin
        s_nxt        = s_r;
        s_nxt.sample = pin;
        s_nxt.prev   = s_r.sample;
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign level = s_r.sample;
    assign fall  = s_r.prev & ~s_r.sample;

endmodule

// ---- logic/udrt_pkg.sv ----
// Constants, register map and state types of the up/down reload timer
// Notes on behaviour
// - 16-bit count from cascaded low/high bytes
// - Select bit picks osc/12 or pin edges
// - Count advances only while run bit set
// - Capture, auto-reload, baud modes from three bits
// - Down-count enable lets direction pin steer count
// - Up overflow after FFFFh: flag, interrupt, reload
// - Down underflow at reload value: flag, load FFFFh
// - Up/down wrap toggles external flag, no external interrupt
// - Clock-out mode counts at half oscillator rate
// - Clock-out overflow reloads, raises no interrupt
// - Clock-out pin toggles each overflow, 50% duty
// - Clock-out drives the count pin as output
// - Baud and clock-out share one reload value
// - Direction pin fall captures or reloads, sets flag
// - Baud select forces auto-reload, feeds serial clock
package udrt_pkg;

    // Register addresses, one byte each
    localparam logic [7:0] ADDR_CTRL       = 8'hC8;
    localparam logic [7:0] ADDR_MODE       = 8'hC9;
    localparam logic [7:0] ADDR_RELOAD_LO  = 8'hCA;
    localparam logic [7:0] ADDR_RELOAD_HI  = 8'hCB;
    localparam logic [7:0] ADDR_COUNT_LO   = 8'hCC;
    localparam logic [7:0] ADDR_COUNT_HI   = 8'hCD;
    localparam logic [7:0] ADDR_IRQ_STAT   = 8'hCE;
    localparam logic [7:0] ADDR_IRQ_MASK   = 8'hCF;

    // Interrupt status and mask bit positions
    localparam int IRQ_OVF_BIT = 0;
    localparam int IRQ_EXT_BIT = 1;

    // Count limits and reset values
    localparam logic [15:0] COUNT_MAX     = 16'hFFFF;
    localparam logic [15:0] COUNT_RST     = 16'h0000;
    localparam logic [15:0] RELOAD_RST    = 16'h0000;
    localparam logic [7:0]  CTRL_RST      = 8'h00;
    localparam logic [7:0]  DATA_ZERO     = 8'h00;

    // Prescaler ratios of the oscillator
    localparam logic [3:0] DIV_TIMER    = 4'hC;
    localparam logic [3:0] DIV_FAST     = 4'h2;
    localparam logic [3:0] DIV_CNT_RST  = 4'h0;

    // Control register layout, bit 7 down to bit 0
    typedef struct packed {
        logic overflow_flag;
        logic external_flag;
        logic rx_baud_select;
        logic tx_baud_select;
        logic external_event_enable;
        logic run_control;
        logic counter_select;
        logic capture_reload_select;
    } udrt_ctrl_s;

    // Mode register layout, low two bits used
    typedef struct packed {
        logic clock_out_enable;
        logic down_count_enable;
    } udrt_mode_s;

    // Timer block state
    typedef struct packed {
        udrt_ctrl_s  ctrl;
        udrt_mode_s  mode;
        logic [15:0] reload;
        logic [15:0] count;
        logic [1:0]  irq_stat;
        logic [1:0]  irq_mask;
        logic [7:0]  rdata;
        logic        irq;
        logic        clk_out;
        logic        rx_tick;
        logic        tx_tick;
    } udrt_state_s;

    // Pin sampler state
    typedef struct packed {
        logic sample;
        logic prev;
    } udrt_pin_s;

    // Prescaler state
    typedef struct packed {
        logic [3:0] cnt;
        logic       tick;
    } udrt_div_s;

endpackage

// ---- logic/udrt_tick_div.sv ----
// Divides the oscillator into a one-cycle tick every RATIO cycles
`timescale 1ns/1ns
module udrt_tick_div
    import udrt_pkg::*;
#(
    parameter logic [3:0] RATIO = DIV_TIMER
) (
    // Clock and reset
    input  wire logic clk,
    input  wire logic nrst,
    // Tick out
    output logic      tick
);

    udrt_div_s s_r;
    udrt_div_s s_nxt;

    always_comb begin
        s_nxt      = s_r;
        s_nxt.tick = 1'b0;
        if (s_r.cnt == RATIO - 4'h1) begin
            s_nxt.cnt  = DIV_CNT_RST;
            s_nxt.tick = 1'b1;
        end else begin
            s_nxt.cnt = s_r.cnt + 4'h1;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign tick = s_r.tick;

endmodule

// ---- logic/udrt_timer.sv ----
// Up/down auto-reload timer/counter with programmable clock output
`timescale 1ns/1ns
module udrt_timer
    import udrt_pkg::*;
(
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       nrst,
    // Register port
    input  wire logic [7:0] addr,
    input  wire logic [7:0] wdata,
    input  wire logic       wr_en,
    input  wire logic       rd_en,
    output logic [7:0]      rdata,
    // Count and clock-out pin
    input  wire logic       count_clockout_pin_in,
    output logic            count_clockout_pin_out,
    output logic            count_clockout_pin_oe,
    // Direction and external event pin
    input  wire logic       direction_pin,
    // Serial port clocks and interrupt
    output logic            rx_baud_tick,
    output logic            tx_baud_tick,
    output logic            irq
);

    udrt_state_s s_r;
    udrt_state_s s_nxt;

    // Sampled pins
    logic pin_level;
    logic pin_fall;
    logic dir_level;
    logic dir_fall;

    // Prescaled ticks
    logic tick_timer;
    logic tick_fast;

    udrt_pin_sample u_count_pin (
        .clk   (clk),
        .nrst  (nrst),
        .pin   (count_clockout_pin_in),
        .level (pin_level),
        .fall  (pin_fall)
    );

    udrt_pin_sample u_dir_pin (
        .clk   (clk),
        .nrst  (nrst),
        .pin   (direction_pin),
        .level (dir_level),
        .fall  (dir_fall)
    );

    udrt_tick_div #(
        .RATIO (DIV_TIMER)
    ) u_div_timer (
        .clk  (clk),
        .nrst (nrst),
        .tick (tick_timer)
    );

    udrt_tick_div #(
        .RATIO (DIV_FAST)
    ) u_div_fast (
        .clk  (clk),
        .nrst (nrst),
        .tick (tick_fast)
    );

    // Mode decode
    logic        baud_mode;
    logic        clkout_mode;
    logic        capture_mode;
    logic        updown_mode;
    logic        reload_on_wrap;
    logic        count_tick;
    logic        count_down;
    logic        at_max;
    logic        at_reload;
    logic        wrap;
    logic        ext_event;
    logic        set_ovf_flag;
    logic        set_ext_flag;
    logic        toggle_ext_flag;
    logic [15:0] count_adv;
    logic [15:0] count_cap;

    always_comb begin
        baud_mode    = s_r.ctrl.rx_baud_select | s_r.ctrl.tx_baud_select;
        clkout_mode  = s_r.mode.clock_out_enable;
        // Baud selection overrides the capture select
        capture_mode = s_r.ctrl.capture_reload_select & ~baud_mode;
        // Direction pin only steers a plain auto-reload timer
        updown_mode  = s_r.mode.down_count_enable & ~capture_mode
                       & ~baud_mode & ~clkout_mode;
        reload_on_wrap = ~capture_mode;
        count_down   = updown_mode & ~dir_level;
        at_max       = (s_r.count == COUNT_MAX);
        at_reload    = (s_r.count == s_r.reload);
        count_cap    = s_r.count;
    end

    // Two byte counters in cascade: low byte carries or borrows into high
    logic [7:0]  low_inc;
    logic [7:0]  high_inc;
    logic        low_carry;
    logic [7:0]  low_dec;
    logic [7:0]  high_dec;
    logic        low_borrow;

    always_comb begin
        {low_carry, low_inc} = {1'b0, s_r.count[7:0]} + 9'h001;
        high_inc             = s_r.count[15:8] + {7'h00, low_carry};
        low_borrow           = (s_r.count[7:0] == DATA_ZERO);
        low_dec              = s_r.count[7:0] - 8'h01;
        high_dec             = s_r.count[15:8] - {7'h00, low_borrow};
    end

    // Count source: pin edges, osc/12, or osc/2 for clock-out and baud
    always_comb begin
        if (s_r.ctrl.counter_select) begin
            count_tick = pin_fall;
        end else if (clkout_mode || baud_mode) begin
            count_tick = tick_fast;
        end else begin
            count_tick = tick_timer;
        end
        count_tick = count_tick & s_r.ctrl.run_control;
    end

    // Next count value and wrap detection
    always_comb begin
        wrap      = 1'b0;
        count_adv = s_r.count;
        if (count_tick) begin
            if (count_down) begin
                if (at_reload) begin
                    wrap      = 1'b1;
                    count_adv = COUNT_MAX;
                end else begin
                    count_adv = {high_dec, low_dec};
                end
            end else if (at_max) begin
                wrap = 1'b1;
                // Wrap from FFFFh loads the reload value, or zero in capture mode
                count_adv = reload_on_wrap ? s_r.reload : COUNT_RST;
            end else begin
                count_adv = {high_inc, low_inc};
            end
        end
    end

    // Flag events
    always_comb begin
        // No overflow flag while feeding the serial port or clocking out
        set_ovf_flag    = wrap & ~baud_mode & ~clkout_mode;
        toggle_ext_flag = wrap & updown_mode;
        ext_event       = s_r.ctrl.external_event_enable & ~baud_mode
                          & ~updown_mode & dir_fall;
        set_ext_flag    = ext_event;
    end

    always_comb begin
        s_nxt         = s_r;
        s_nxt.rdata   = DATA_ZERO;
        s_nxt.rx_tick = 1'b0;
        s_nxt.tx_tick = 1'b0;

        // Counting
        s_nxt.count = count_adv;

        // Clock-out pin toggles on every wrap, giving 50% duty
        if (wrap && clkout_mode) begin
            s_nxt.clk_out = ~s_r.clk_out;
        end

        // Serial clocks from the same wrap, sharing the reload value
        if (wrap) begin
            s_nxt.rx_tick = s_r.ctrl.rx_baud_select;
            s_nxt.tx_tick = s_r.ctrl.tx_baud_select;
        end

        // External event: capture into reload, or force reload
        if (ext_event) begin
            if (capture_mode) begin
                s_nxt.reload = count_cap;
            end else begin
                s_nxt.count = s_r.reload;
            end
        end

        // Software writes; a write to the count wins over a tick
        if (wr_en) begin
            case (addr)
                ADDR_CTRL: begin
                    s_nxt.ctrl = udrt_ctrl_s'(wdata);
                end
                ADDR_MODE: begin
                    s_nxt.mode = udrt_mode_s'(wdata[1:0]);
                end
                ADDR_RELOAD_LO: begin
                    s_nxt.reload[7:0] = wdata;
                end
                ADDR_RELOAD_HI: begin
                    s_nxt.reload[15:8] = wdata;
                end
                ADDR_COUNT_LO: begin
                    s_nxt.count[7:0] = wdata;
                end
                ADDR_COUNT_HI: begin
                    s_nxt.count[15:8] = wdata;
                end
                ADDR_IRQ_MASK: begin
                    s_nxt.irq_mask = wdata[1:0];
                end
                default: begin
                end
            endcase
        end

        // Hardware sets win over a software clear in the same cycle
        if (set_ovf_flag) begin
            s_nxt.ctrl.overflow_flag = 1'b1;
        end
        if (set_ext_flag) begin
            s_nxt.ctrl.external_flag = 1'b1;
        end
        if (toggle_ext_flag) begin
            s_nxt.ctrl.external_flag = ~s_nxt.ctrl.external_flag;
        end

        // Sticky status: read clears, new event wins
        if (rd_en && addr == ADDR_IRQ_STAT) begin
            s_nxt.irq_stat = 2'h0;
        end
        if (set_ovf_flag) begin
            s_nxt.irq_stat[IRQ_OVF_BIT] = 1'b1;
        end
        // Up/down wrap toggles never reach the external interrupt bit
        if (set_ext_flag) begin
            s_nxt.irq_stat[IRQ_EXT_BIT] = 1'b1;
        end
        s_nxt.irq = |(s_nxt.irq_stat & s_nxt.irq_mask);

        // Read data, valid the cycle after the strobe
        if (rd_en) begin
            case (addr)
                ADDR_CTRL: begin
                    s_nxt.rdata = s_r.ctrl;
                end
                ADDR_MODE: begin
                    s_nxt.rdata = {6'h00, s_r.mode};
                end
                ADDR_RELOAD_LO: begin
                    s_nxt.rdata = s_r.reload[7:0];
                end
                ADDR_RELOAD_HI: begin
                    s_nxt.rdata = s_r.reload[15:8];
                end
                ADDR_COUNT_LO: begin
                    s_nxt.rdata = s_r.count[7:0];
                end
                ADDR_COUNT_HI: begin
                    s_nxt.rdata = s_r.count[15:8];
                end
                ADDR_IRQ_STAT: begin
                    s_nxt.rdata = {6'h00, s_r.irq_stat};
                end
                ADDR_IRQ_MASK: begin
                    s_nxt.rdata = {6'h00, s_r.irq_mask};
                end
                default: begin
                    s_nxt.rdata = DATA_ZERO;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            s_r          <= '0;
            s_r.ctrl     <= udrt_ctrl_s'(CTRL_RST);
            s_r.count    <= COUNT_RST;
            s_r.reload   <= RELOAD_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    // Outputs straight from state
    assign rdata                  = s_r.rdata;
    assign irq                    = s_r.irq;
    assign rx_baud_tick           = s_r.rx_tick;
    assign tx_baud_tick           = s_r.tx_tick;
    assign count_clockout_pin_out = s_r.clk_out;
    // Pin turns into an output only when clock-out is enabled
    assign count_clockout_pin_oe  = s_r.mode.clock_out_enable;

    // Sampled count pin level is unused beyond its edge
    logic unused_pin_level;
    assign unused_pin_level = pin_level;

endmodule

// ---- test/test_updown_reload_timer_clockout.sv ----
// Self-checking bench of the up/down reload timer
`timescale 1ns/1ns
module test_updown_reload_timer_clockout
    import udrt_pkg::*;
;
    logic        clk = 1'b0;
    logic        nrst = 1'b0;
    logic [7:0]  addr = 8'h00;
    logic [7:0]  wdata = 8'h00;
    logic        wr_en = 1'b0;
    logic        rd_en = 1'b0;
    logic        go = 1'b0;
    logic        slow = 1'b0;
    logic        dir_lvl = 1'b1;
    logic [7:0]  rdata, v;
    logic        pin_out, pin_oe, pin_in, dir_pin, rx_tick, tx_tick, irq, busy;
    logic [31:0] seed = 32'h4699210C;
    logic [15:0] r;
    int          half_len, n, t, m_cnt, m_rel;
    logic        m_ovf, m_ext;
    int          bad_count = 0;
    int          num_checks = 0;
    int          cycles = 0;

    always #50 clk = ~clk;

    udrt_timer i_udrt_timer (
        .clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en),
        .rdata(rdata), .count_clockout_pin_in(pin_in), .count_clockout_pin_out(pin_out),
        .count_clockout_pin_oe(pin_oe), .direction_pin(dir_pin), .rx_baud_tick(rx_tick),
        .tx_baud_tick(tx_tick), .irq(irq)
    );
    udrt_pin_model i_udrt_pin_model (
        .clk(clk), .pin_out(pin_out), .pin_oe(pin_oe), .pin_in(pin_in), .dir_pin(dir_pin),
        .go(go), .slow(slow), .dir_lvl(dir_lvl), .busy(busy), .half_len(half_len)
    );

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    task automatic complete_run();
        if (bad_count == 0 && num_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic chk(input string s, input logic [15:0] e, input logic [15:0] g);
        num_checks++;
        if (g !== e) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", s, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        #1 d = rdata;
    endtask
    task automatic wr16(input logic [7:0] a, input logic [15:0] d);
        wr(a, d[7:0]);
        wr(a + 8'h01, d[15:8]);
    endtask
    task automatic rc(input logic [7:0] a, input logic [7:0] e, input string s);
        rd(a, v);
        chk(s, {8'h00, e}, {8'h00, v});
    endtask
    task automatic rc16(input logic [7:0] a, input logic [15:0] e, input string s);
        logic [7:0] lo;
        rd(a, lo);
        rd(a + 8'h01, v);
        chk(s, e, {v, lo});
    endtask
    task automatic irq_is(input logic e);
        repeat (2) @(posedge clk);
        #1 chk("irq", {15'h0000, e}, {15'h0000, irq});
    endtask
    // Falling edges from the far side; slow and fast pulses alternate
    task automatic pulse(input int k);
        repeat (k) begin
            @(posedge clk);
            go <= 1'b1;
            slow <= ~slow;
            @(posedge clk);
            go <= 1'b0;
            @(posedge clk);
            while (busy) @(posedge clk);
        end
    endtask
    // Reference count; ext toggling only matters in up/down mode
    task automatic m_tick(input logic up);
        if (up && m_cnt == 65535) begin
            m_cnt = m_rel;
            m_ovf = 1'b1;
            m_ext = ~m_ext;
        end else if (!up && m_cnt == m_rel) begin
            m_cnt = 65535;
            m_ovf = 1'b1;
            m_ext = ~m_ext;
        end else begin
            m_cnt = up ? m_cnt + 1 : m_cnt - 1;
        end
    endtask

    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            bad_count++;
            complete_run();
        end
    end

    initial begin
        repeat (5) @(posedge clk);
        nrst <= 1'b1;
        for (int a = 8'hC8; a <= 8'hD0; a++) begin
            rc(a[7:0], 8'h00, "reset value");
        end
        wr(8'h10, 8'hFF);
        rc(8'h10, 8'h00, "unmapped");
        // Counter mode across the byte carry, then frozen
        seed = xs(seed);
        n = 2 + seed[2:0];
        m_cnt = 'h00FE;
        wr16(ADDR_COUNT_LO, 16'h00FE);
        wr(ADDR_CTRL, 8'h06);
        pulse(n);
        wr(ADDR_CTRL, 8'h02);
        pulse(2);
        repeat (n) m_tick(1'b1);
        rc16(ADDR_COUNT_LO, m_cnt[15:0], "pin count");
        // Timer mode overflow with interrupt raised, masked and cleared
        wr(ADDR_IRQ_MASK, 8'h01);
        wr16(ADDR_RELOAD_LO, 16'hFFF0);
        wr16(ADDR_COUNT_LO, 16'hFFFE);
        m_rel = 'hFFF0;
        m_cnt = 'hFFFE;
        repeat (2) m_tick(1'b1);
        wr(ADDR_CTRL, 8'h04);
        t = 0;
        while (irq !== 1'b1) begin
            @(posedge clk);
            t++;
        end
        chk("slow wrap", 16'h0001, {15'h0000, t >= 13});
        rc(ADDR_CTRL, 8'h84, "overflow flag");
        wr(ADDR_CTRL, 8'h00);
        rc16(ADDR_COUNT_LO, m_cnt[15:0], "reloaded");
        wr(ADDR_IRQ_MASK, 8'h00);
        irq_is(1'b0);
        wr(ADDR_IRQ_MASK, 8'h01);
        irq_is(1'b1);
        rc(ADDR_IRQ_STAT, 8'h01, "status");
        irq_is(1'b0);
        rc(ADDR_IRQ_STAT, 8'h00, "status cleared");
        // Up/down: underflow at the reload value, then overflow
        wr(ADDR_MODE, 8'h01);
        wr16(ADDR_RELOAD_LO, 16'h0005);
        wr16(ADDR_COUNT_LO, 16'h0006);
        m_rel = 5;
        m_cnt = 6;
        m_ovf = 1'b0;
        m_ext = 1'b0;
        dir_lvl <= 1'b0;
        wr(ADDR_CTRL, 8'h06);
        pulse(2);
        repeat (2) m_tick(1'b0);
        rc(ADDR_CTRL, {m_ovf, m_ext, 6'h06}, "down flags");
        rc16(ADDR_COUNT_LO, m_cnt[15:0], "underflow");
        @(posedge clk);
        dir_lvl <= 1'b1;
        pulse(1);
        m_tick(1'b1);
        rc(ADDR_CTRL, {m_ovf, m_ext, 6'h06}, "up flags");
        rc16(ADDR_COUNT_LO, m_cnt[15:0], "overflow");
        rc(ADDR_IRQ_STAT, 8'h01, "no ext irq");
        wr(ADDR_CTRL, 8'h00);
        wr(ADDR_MODE, 8'h00);
        // Direction pin event: capture first, then reload
        seed = xs(seed);
        r = seed[15:0];
        wr(ADDR_IRQ_MASK, 8'h02);
        for (int c = 1; c >= 0; c--) begin
            wr16(ADDR_COUNT_LO, c ? r : 16'h0000);
            wr(ADDR_CTRL, 8'h08 | c[7:0]);
            dir_lvl <= 1'b0;
            while (irq !== 1'b1) @(posedge clk);
            rc(ADDR_CTRL, 8'h48 | c[7:0], "ext flag");
            rc16(c ? ADDR_RELOAD_LO : ADDR_COUNT_LO, r, "event load");
            rc(ADDR_IRQ_STAT, 8'h02, "ext status");
            @(posedge clk);
            dir_lvl <= 1'b1;
        end
        // Clock out shared with both baud clocks, capture bit ignored
        wr(ADDR_CTRL, 8'h00);
        wr(ADDR_IRQ_MASK, 8'h03);
        seed = xs(seed);
        r = 16'hFFF8 | {13'h0000, seed[2:0]};
        wr(ADDR_MODE, 8'h02);
        wr16(ADDR_RELOAD_LO, r);
        wr16(ADDR_COUNT_LO, r);
        wr(ADDR_CTRL, 8'h35);
        repeat (80) @(posedge clk);
        chk("half period", 16'(2 * (65536 - int'(r))), half_len[15:0]);
        while (tx_tick !== 1'b1) @(posedge clk);
        t = 0;
        do begin
            @(posedge clk);
            t++;
        end while (tx_tick !== 1'b1);
        chk("tick gap", 16'(2 * (65536 - int'(r))), t[15:0]);
        chk("rx tick", 16'h0001, {15'h0000, rx_tick});
        chk("pin enable", 16'h0001, {15'h0000, pin_oe});
        chk("no irq", 16'h0000, {15'h0000, irq});
        rc(ADDR_IRQ_STAT, 8'h00, "clock-out status");
        rc(ADDR_CTRL, 8'h35, "baud control");
        complete_run();
    end
endmodule

// ---- test/udrt_pin_model.sv ----
// Far side of the timer pins: count pulses, direction level, clock-out timing
`timescale 1ns/1ns
module udrt_pin_model (
    // Clock
    input  wire logic clk,
    // Timer pins
    input  wire logic pin_out,
    input  wire logic pin_oe,
    output logic      pin_in,
    output logic      dir_pin,
    // Bench control
    input  wire logic go,
    input  wire logic slow,
    input  wire logic dir_lvl,
    output logic      busy,
    output int        half_len
);
    int   ph = 0;
    int   run = 0;
    logic last = 1'b0;
    // Pull-up holds the pin high whenever nobody drives it low
    assign pin_in  = pin_oe ? pin_out : (ph < 3);
    assign dir_pin = dir_lvl;
    assign busy    = (ph != 0);
    always @(posedge clk) begin
        if (go && ph == 0) begin
            ph <= slow ? 10 : 4;
        end else if (ph != 0) begin
            ph <= ph - 1;
        end
        if (pin_in != last) begin
            half_len <= run + 1;
            run <= 0;
        end else begin
            run <= run + 1;
        end
        last <= pin_in;
    end
endmodule

// ---- test/udrt_timer_chk.sv ----
// Port assertions of the reload timer
`timescale 1ns/1ns
module udrt_timer_chk
    import udrt_pkg::*;
(
    // Clock and reset
    input wire logic       clk,
    input wire logic       nrst,
    // Register port
    input wire logic       wr_en,
    input wire logic       rd_en,
    // Outputs
    input wire logic       count_clockout_pin_out,
    input wire logic       count_clockout_pin_oe,
    input wire logic       rx_baud_tick,
    input wire logic       tx_baud_tick,
    input wire logic       irq
);
    logic       out_d_r;
    int         half_r;
    int         last_r;
    logic [1:0] seen_r;
    wire        tog = count_clockout_pin_out ^ out_d_r;
    // Halves are only comparable once a write no longer disturbs them
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            out_d_r <= 1'b0;
            half_r <= 0;
            last_r <= 0;
            seen_r <= 2'h0;
        end else begin
            out_d_r <= count_clockout_pin_out;
            half_r <= tog ? 0 : half_r + 1;
            last_r <= tog ? half_r + 1 : last_r;
            seen_r <= wr_en ? 2'h0 : (tog && seen_r != 2'h3) ? seen_r + 2'h1 : seen_r;
        end
    end
    default clocking @(posedge clk);
    endclocking
    default disable iff (!nrst);
    clkout_gap_a: assert property ($changed(count_clockout_pin_out) |=>
        $stable(count_clockout_pin_out)) else $error("clock out toggled twice in a row");
    duty_even_a: assert property (tog && seen_r >= 2'h2 |-> half_r + 1 == last_r)
        else $error("clock out halves differ");
    out_needs_oe_a: assert property ($changed(count_clockout_pin_out) |->
        count_clockout_pin_oe || $past(count_clockout_pin_oe)) else $error("pin moved undriven");
    oe_by_write_a: assert property ($changed(count_clockout_pin_oe) |->
        $past(wr_en) || $past(wr_en, 2)) else $error("output enable moved without a write");
    rx_pulse_a: assert property (rx_baud_tick |=> !rx_baud_tick)
        else $error("receive tick longer than one cycle");
    tx_pulse_a: assert property (tx_baud_tick |=> !tx_baud_tick)
        else $error("transmit tick longer than one cycle");
    tick_toggles_a: assert property (tx_baud_tick && count_clockout_pin_oe |->
        $changed(count_clockout_pin_out)) else $error("baud wrap without clock toggle");
    irq_fall_a: assert property ($fell(irq) |-> $past(rd_en || wr_en) ||
        $past(rd_en || wr_en, 2)) else $error("interrupt dropped without an access");
    cover property ($rose(irq));
    cover property (tx_baud_tick && rx_baud_tick);
    cover property (tog && seen_r >= 2'h2);
endmodule
bind udrt_timer udrt_timer_chk i_udrt_timer_chk (
    .clk(clk), .nrst(nrst), .wr_en(wr_en), .rd_en(rd_en),
    .count_clockout_pin_out(count_clockout_pin_out),
    .count_clockout_pin_oe(count_clockout_pin_oe),
    .rx_baud_tick(rx_baud_tick), .tx_baud_tick(tx_baud_tick), .irq(irq)
);
